// >>> core/apc_counter.sv
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module apc_counter
   import apc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        scan_tick,
   input  wire logic        count_in,
   input  wire logic        clear_in,
   output logic             count_out,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   logic [31:0] ctrl_r;
   logic [31:0] count_threshold_r;
   logic [31:0] count_r;
   logic [31:0] count_nxt;
   logic        prev_in_r;
   logic        done_r;
   logic        hold_r;
   logic        clear_act;
   logic        wide;
   logic [31:0] lim;
   logic [31:0] thr;
   logic        rise;
   logic        done_nxt;
   logic        out_nxt;
   logic [7:0]  aw_r;
   logic        aw_ok_r;
   logic [31:0] wd_r;
   logic [3:0]  ws_r;
   logic        wd_ok_r;
   apc_state_t  st;

   function automatic logic [31:0] apc_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic apc_mapped(input logic [7:0] a);
      return a == APC_CTRL_OFS || a == APC_THRESH_OFS || a == APC_COUNT_OFS ||
             a == APC_STAT_OFS;
   endfunction

   // clear counts only when connected; unconnected means never cleared
   assign clear_act = ctrl_r[APC_CTRL_CONN_BIT] & (clear_in | ctrl_r[APC_CTRL_CLR_BIT]);
   assign wide      = ctrl_r[APC_CTRL_WID_BIT];
   assign lim       = wide ? 32'hFFFF_FFFF : APC_WORD_MAX;
   assign thr       = count_threshold_r & lim;
   assign rise      = count_in & ~prev_in_r;

   always_comb begin
      count_nxt = count_r;
      done_nxt  = done_r;
      if (clear_act) begin
         count_nxt = '0;
         done_nxt  = (thr == '0);
      end else if (done_r || count_r >= thr) begin
         done_nxt = 1'b1;
      end else if (rise && !hold_r && count_r < lim) begin
         count_nxt = count_r + 32'h0000_0001;
         done_nxt  = (count_r + 32'h0000_0001) >= thr;
      end
      // output follows comparison; suppressed while clearing
      out_nxt = !clear_act && (count_nxt >= thr || done_nxt);
   end

   // all counter state steps once per scan tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_r   <= '0;
         done_r    <= 1'b0;
         hold_r    <= 1'b0;
         prev_in_r <= 1'b0;
         count_out <= 1'b0;
      end else if (scan_tick) begin
         prev_in_r <= count_in;
         count_r   <= count_nxt;
         done_r    <= done_nxt;
         hold_r    <= clear_act;
         count_out <= out_nxt;
      end
   end

   always_comb begin
      if (clear_act) begin
         st = APC_ST_CLEAR;
      end else if (hold_r) begin
         st = APC_ST_HOLD;
      end else if (done_r) begin
         st = APC_ST_DONE;
      end else begin
         st = APC_ST_COUNT;
      end
   end

   // write channel: address and data latched independently
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready     <= 1'b1;
         s_axi_wready      <= 1'b1;
         aw_ok_r           <= 1'b0;
         wd_ok_r           <= 1'b0;
         aw_r              <= '0;
         wd_r              <= '0;
         ws_r              <= '0;
         s_axi_bvalid      <= 1'b0;
         s_axi_bresp       <= APC_RESP_OKAY;
         ctrl_r            <= APC_CTRL_RST;
         count_threshold_r <= APC_THRESH_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_r          <= s_axi_awaddr[7:0];
            aw_ok_r       <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd_r         <= s_axi_wdata;
            ws_r         <= s_axi_wstrb;
            wd_ok_r      <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_ok_r && wd_ok_r && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= apc_mapped(aw_r) ? APC_RESP_OKAY : APC_RESP_SLVERR;
            case (aw_r)
               APC_CTRL_OFS: begin
                  ctrl_r <= apc_merge(ctrl_r, wd_r, ws_r) & 32'h0000_0007;
               end
               APC_THRESH_OFS: begin
                  count_threshold_r <= apc_merge(count_threshold_r, wd_r, ws_r);
               end
               default: begin
               end
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_ok_r       <= 1'b0;
            wd_ok_r       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= APC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= apc_mapped(s_axi_araddr[7:0]) ? APC_RESP_OKAY : APC_RESP_SLVERR;
         case (s_axi_araddr[7:0])
            APC_CTRL_OFS:   s_axi_rdata <= ctrl_r;
            APC_THRESH_OFS: s_axi_rdata <= count_threshold_r;
            APC_COUNT_OFS:  s_axi_rdata <= count_r;
            APC_STAT_OFS:   s_axi_rdata <= {27'h0, st, hold_r, done_r, count_out};
            default:        s_axi_rdata <= '0;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   property p_clear_zero;
      @(posedge aclk) disable iff (!aresetn)
      scan_tick && clear_act |=> count_r == '0 && !count_out;
   endproperty
   a_clear_zero: assert property (p_clear_zero)
      else $error("clear did not zero count and output");
   property p_one_step;
      @(posedge aclk) disable iff (!aresetn)
      scan_tick && !clear_act |=> count_r == $past(count_r) ||
         count_r == $past(count_r) + 32'h0000_0001;
   endproperty
   a_one_step: assert property (p_one_step)
      else $error("count moved by more than one");
   property p_no_level;
      @(posedge aclk) disable iff (!aresetn)
      scan_tick && !rise && !clear_act |=> count_r == $past(count_r);
   endproperty
   a_no_level: assert property (p_no_level)
      else $error("count changed without edge");
   property p_hold_scan;
      @(posedge aclk) disable iff (!aresetn)
      scan_tick && hold_r && !clear_act |=> count_r == $past(count_r);
   endproperty
   a_hold_scan: assert property (p_hold_scan)
      else $error("count changed in scan after clear");
   property p_ge_out;
      @(posedge aclk) disable iff (!aresetn)
      scan_tick && !clear_act && count_nxt >= thr |=> count_out;
   endproperty
   a_ge_out: assert property (p_ge_out)
      else $error("output low at or above threshold");
   property p_lt_out;
      @(posedge aclk) disable iff (!aresetn)
      scan_tick && !done_nxt && count_nxt < thr |=> !count_out;
   endproperty
   a_lt_out: assert property (p_lt_out)
      else $error("output high below threshold");
   property p_stop;
      @(posedge aclk) disable iff (!aresetn)
      scan_tick && done_r && !clear_act |=> count_out && count_r == $past(count_r);
   endproperty
   a_stop: assert property (p_stop)
      else $error("count moved after reaching threshold");
   property p_width;
      @(posedge aclk) disable iff (!aresetn)
      !wide && !$past(wide) |-> count_r <= APC_WORD_MAX || $stable(count_r);
   endproperty
   a_width: assert property (p_width)
      else $error("word mode count exceeded range");
endmodule

// >>> core/apc_pkg.sv
package apc_pkg;
   // register byte offsets
   localparam logic [7:0]  APC_CTRL_OFS   = 8'h00;
   localparam logic [7:0]  APC_THRESH_OFS = 8'h04;
   localparam logic [7:0]  APC_COUNT_OFS  = 8'h08;
   localparam logic [7:0]  APC_STAT_OFS   = 8'h0C;
   // control field positions
   localparam int          APC_CTRL_CLR_BIT  = 0;
   localparam int          APC_CTRL_WID_BIT  = 1;
   localparam int          APC_CTRL_CONN_BIT = 2;
   // status field positions
   localparam int          APC_STAT_OUT_BIT  = 0;
   localparam int          APC_STAT_DONE_BIT = 1;
   localparam int          APC_STAT_HOLD_BIT = 2;
   // reset values, word-mode count limit and response codes
   localparam logic [31:0] APC_CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] APC_THRESH_RST = 32'h0000_0000;
   localparam logic [31:0] APC_WORD_MAX   = 32'h0000_FFFF;
   localparam logic [1:0]  APC_RESP_OKAY   = 2'b00;
   localparam logic [1:0]  APC_RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      APC_ST_CLEAR = 2'b00,
      APC_ST_HOLD  = 2'b01,
      APC_ST_COUNT = 2'b11,
      APC_ST_DONE  = 2'b10
   } apc_state_t;
endpackage

// >>> testbench/apc_prog_model.sv
`timescale 1ns/100ps
module apc_prog_model (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic count_lvl,
   input  wire logic clear_lvl,
   output logic      scan_tick,
   output logic      count_in,
   output logic      clear_in
);
   logic [1:0] div_r;
   // program logic moves its outputs once per scan, never between ticks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= 2'h0;
         scan_tick <= 1'b0;
         count_in <= 1'b0;
         clear_in <= 1'b0;
      end else begin
         div_r <= div_r + 2'h1;
         scan_tick <= (div_r == 2'h3);
         if (scan_tick) begin
            count_in <= count_lvl;
            clear_in <= clear_lvl;
         end
      end
   end
endmodule

// >>> testbench/tb.sv
`timescale 1ns/100ps
module tb;
   import apc_pkg::*;
   logic aclk, aresetn, count_lvl, clear_lvl, scan_tick, count_in, clear_in, count_out;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   int n_errors, comparisons;
   apc_prog_model prog (.aclk(aclk), .aresetn(aresetn), .count_lvl(count_lvl),
      .clear_lvl(clear_lvl),
      .scan_tick(scan_tick), .count_in(count_in), .clear_in(clear_in));
   apc_counter dut (.aclk(aclk), .aresetn(aresetn), .scan_tick(scan_tick),
      .count_in(count_in), .clear_in(clear_in), .count_out(count_out),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic complete_run();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int i;
      awaddr <= {24'h00_0000, a};
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 20 && !bvalid; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      if (i == 20) begin
         n_errors++;
         complete_run();
      end
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int i;
      araddr <= {24'h00_0000, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 20 && !rvalid; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end
      if (i == 20) begin
         n_errors++;
         complete_run();
      end
      rready <= 1'b0;
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
      @(posedge aclk);
   endtask
   // one high level spanning two scans, then two low scans
   task automatic pulse();
      count_lvl <= 1'b1;
      repeat (8) @(posedge aclk);
      count_lvl <= 1'b0;
      repeat (8) @(posedge aclk);
   endtask
   task automatic t_regs();
      rd(APC_CTRL_OFS, APC_CTRL_RST, APC_RESP_OKAY);
      rd(APC_THRESH_OFS, APC_THRESH_RST, APC_RESP_OKAY);
      rd(8'h10, 32'h0000_0000, APC_RESP_SLVERR);
      wr(8'h14, 32'h0000_0001, APC_RESP_SLVERR);
   endtask
   task automatic t_count();
      wr(APC_CTRL_OFS, 32'h0000_0006, APC_RESP_OKAY);
      wr(APC_THRESH_OFS, 32'h0000_0003, APC_RESP_OKAY);
      // zero threshold since reset has already ended counting: clear first
      wr(APC_CTRL_OFS, 32'h0000_0007, APC_RESP_OKAY);
      repeat (8) @(posedge aclk);
      rd(APC_COUNT_OFS, 32'h0000_0000, APC_RESP_OKAY);
      wr(APC_CTRL_OFS, 32'h0000_0006, APC_RESP_OKAY);
      pulse();
      rd(APC_COUNT_OFS, 32'h0000_0001, APC_RESP_OKAY);
      chk({31'h0, count_out}, 32'h0000_0000);
      pulse();
      pulse();
      chk({31'h0, count_out}, 32'h0000_0001);
      pulse();
      rd(APC_COUNT_OFS, 32'h0000_0003, APC_RESP_OKAY);
   endtask
   task automatic t_clear();
      clear_lvl <= 1'b1;
      pulse();
      rd(APC_COUNT_OFS, 32'h0000_0000, APC_RESP_OKAY);
      chk({31'h0, count_out}, 32'h0000_0000);
      clear_lvl <= 1'b0;
      pulse();
      pulse();
      rd(APC_COUNT_OFS, 32'h0000_0001, APC_RESP_OKAY);
   endtask
   task automatic t_word();
      wr(APC_CTRL_OFS, 32'h0000_0000, APC_RESP_OKAY);
      clear_lvl <= 1'b1;
      pulse();
      rd(APC_COUNT_OFS, 32'h0000_0002, APC_RESP_OKAY);
      // threshold above 16 bits is only in range once double width is chosen
      wr(APC_CTRL_OFS, 32'h0000_0002, APC_RESP_OKAY);
      wr(APC_THRESH_OFS, 32'h0001_0005, APC_RESP_OKAY);
      rd(APC_THRESH_OFS, 32'h0001_0005, APC_RESP_OKAY);
      repeat (3) pulse();
      rd(APC_COUNT_OFS, 32'h0000_0005, APC_RESP_OKAY);
      // a 16-bit compare would see 5 here and raise the output
      chk({31'h0, count_out}, 32'h0000_0000);
      wr(APC_THRESH_OFS, 32'h0000_0000, APC_RESP_OKAY);
      repeat (8) @(posedge aclk);
      chk({31'h0, count_out}, 32'h0000_0001);
   endtask
   initial begin
      {aresetn, count_lvl, clear_lvl, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
      {awaddr, wdata, araddr} = 96'h0;
      wstrb = 4'hF;
      n_errors = 0;
      comparisons = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_count();
      t_clear();
      t_word();
      complete_run();
   end
endmodule
